//--- hdl/ui_cmd_interp.sv
// command interpreter for user-interface info, control read/props/write
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - info selector: general, dialog index, control id
// - one info answer, two for control
// - info queries pass on without validation
// - control id directly follows command byte
// - read gives responses of sixteen bytes each
// - reads and writes work without server running
// - properties frame is exactly twelve bytes
// - properties go only to a connected client
// - four property bytes then four colour bytes
// - message zero shows, one only updates
// - icon low nibble, buttons high nibble v3
// - 0x10 forces visible, 0x40 applies colour
// - colour bytes red, green, blue, zero
// - write places data at little-endian offset
// - offset-zero write completes and sends value
// - latch value is one byte
// - password and section are one byte
// - number and list are four bytes
// - date-time eight bytes, some none, configured
// - message shown without regard to parent
// - frame starts with its total length
// - text form uses hex pairs and cr/lf
module ui_cmd_interp
    import ui_cmd_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic text_mode_i,
    input wire logic client_conn_i,
    input wire logic client_v3_i,
    input wire logic [3:0] ctl_type_i,
    input wire logic [15:0] ctl_cfg_size_i,
    output logic [15:0] ctl_id_o,
    output logic info_valid_o,
    output info_req_t info_o,
    output logic rd_valid_o,
    output logic [7:0] rd_seg_cnt_o,
    output logic props_valid_o,
    output props_t props_o,
    output logic wr_valid_o,
    output wr_t wr_o,
    output logic commit_o,
    output logic frame_err_o
);
    typedef enum logic [1:0] {ST_LEN, ST_BODY, ST_EXEC} state_t;

    state_t state_q;
    state_t state_d;
    logic b_valid;
    logic [7:0] b_data;
    logic [7:0] len_q;
    logic [7:0] idx_q;
    logic [7:0] cmd_q;
    logic [7:0] cap_q [CAP_BYTES];
    logic [4:0] wr_cnt_q;
    logic seg_err_q;
    logic take_len;
    logic in_body;
    logic last_byte;
    logic wr_byte;
    logic wr_over;
    logic [15:0] id_w;
    logic [15:0] off_w;
    logic [7:0] prop0;
    logic [7:0] prop2;
    logic is_msg;
    logic [15:0] ctl_size;
    logic [16:0] size_round;
    logic [7:0] seg_cnt;
    logic exec;
    logic [15:0] info_arg;

    // text frames are reduced to the binary byte stream first
    hex_pair_decoder u_hex (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .text_mode_i(text_mode_i),
        .in_valid_i(rx_valid_i),
        .in_data_i(rx_data_i),
        .out_valid_o(b_valid),
        .out_data_o(b_data)
    );

    // frame walk; a length byte may arrive during the execute cycle
    assign take_len = b_valid && (state_q != ST_BODY);
    assign in_body = b_valid && (state_q == ST_BODY);
    assign last_byte = in_body && (idx_q == 8'(len_q - 8'h01));
    assign exec = (state_q == ST_EXEC);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_LEN: begin
                if (take_len && b_data >= MIN_FRAME_LEN) begin
                    state_d = ST_BODY;
                end
            end
            ST_BODY: begin
                if (last_byte) begin
                    state_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                state_d = (take_len && b_data >= MIN_FRAME_LEN)
                    ? ST_BODY : ST_LEN;
            end
            default: begin
                state_d = ST_LEN;
            end
        endcase
    end

    // length and position tracking; a short length byte is skipped
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_q <= ST_LEN;
            len_q <= 8'h00;
            idx_q <= 8'h00;
        end else begin
            state_q <= state_d;
            if (take_len) begin
                len_q <= b_data;
                idx_q <= POS_CMD;
            end else if (in_body) begin
                idx_q <= 8'(idx_q + 8'h01);
            end
        end
    end

    // command byte capture
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cmd_q <= 8'h00;
        end else if (in_body && idx_q == POS_CMD) begin
            cmd_q <= b_data;
        end
    end

    // parameter bytes after the command land in a small capture array
    for (genvar g = 0; g < CAP_BYTES; g++) begin : g_cap
        always_ff @(posedge clk_sys_i) begin
            if (sys_rst_i) begin
                cap_q[g] <= 8'h00;
            end else if (in_body && idx_q == 8'(g + 2)) begin
                cap_q[g] <= b_data;
            end
        end
    end

    // field decode: id high byte first, offset low byte first
    assign id_w = {cap_q[0], cap_q[1]};
    assign off_w = {cap_q[3], cap_q[2]};
    assign prop0 = cap_q[2];
    assign prop2 = cap_q[4];
    assign is_msg = (ctl_type_i == TYPE_MESSAGE);

    // the lookup port sees the id as soon as its low byte arrives
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            ctl_id_o <= 16'h0000;
        end else if (in_body && idx_q == POS_ID_LO
                && cmd_q != CMD_UI_INFO) begin
            ctl_id_o <= {cap_q[0], b_data};
        end else if (in_body && idx_q == 8'h04 && cmd_q == CMD_UI_INFO) begin
            ctl_id_o <= {cap_q[1], b_data};
        end
    end

    // storage size by control type; the store's configured size
    // is only trusted for blob and text
    always_comb begin
        case (ctl_type_i)
            TYPE_LATCH: ctl_size = SIZE_FLAG;
            TYPE_PASSWORD: ctl_size = SIZE_FLAG;
            TYPE_SECTION: ctl_size = SIZE_FLAG;
            TYPE_NUMBER: ctl_size = SIZE_WORD;
            TYPE_LIST: ctl_size = SIZE_WORD;
            TYPE_DATE_TIME: ctl_size = SIZE_DATE_TIME;
            TYPE_BLOB: ctl_size = ctl_cfg_size_i;
            TYPE_TEXT: ctl_size = ctl_cfg_size_i;
            default: ctl_size = 16'h0000;
        endcase
    end

    // at least one response, one per started sixteen bytes
    assign size_round = {1'b0, ctl_size} + SEG_ROUND;
    assign seg_cnt = (ctl_size == 16'h0000) ? 8'h01 : size_round[11:4];

    // data bytes of a write stream out as they arrive
    assign wr_byte = in_body && cmd_q == CMD_SET_DATA && idx_q >= POS_DATA;
    assign wr_over = (wr_cnt_q == SEG_MAX_BYTES);

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            wr_cnt_q <= 5'h00;
            seg_err_q <= 1'b0;
        end else if (take_len) begin
            wr_cnt_q <= 5'h00;
            seg_err_q <= 1'b0;
        end else if (wr_byte) begin
            if (wr_over) begin
                seg_err_q <= 1'b1;
            end else begin
                wr_cnt_q <= 5'(wr_cnt_q + 5'h01);
            end
        end
    end

    // store write port; server state is not consulted at all
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            wr_valid_o <= 1'b0;
            wr_o <= '0;
        end else begin
            wr_valid_o <= wr_byte && !wr_over;
            if (wr_byte && !wr_over) begin
                wr_o.id <= id_w;
                wr_o.addr <= 16'(off_w + {11'h000, wr_cnt_q});
                wr_o.data <= b_data;
            end
        end
    end

    // info argument depends on the selector, unknown ones pass unchecked
    assign info_arg = (cap_q[0] == INFO_CONTROL) ? {cap_q[1], cap_q[2]}
        : (cap_q[0] == INFO_DIALOG) ? {8'h00, cap_q[1]} : 16'h0000;

    // command execution in the cycle after the last frame byte
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            info_valid_o <= 1'b0;
            info_o <= '0;
            rd_valid_o <= 1'b0;
            rd_seg_cnt_o <= 8'h00;
            commit_o <= 1'b0;
            frame_err_o <= 1'b0;
        end else begin
            info_valid_o <= exec && cmd_q == CMD_UI_INFO;
            rd_valid_o <= exec && cmd_q == CMD_GET_CTL;
            commit_o <= exec && cmd_q == CMD_SET_DATA && !seg_err_q
                && len_q >= POS_DATA && off_w == 16'h0000;
            frame_err_o <= exec && ((cmd_q == CMD_SET_PROPS
                && len_q != PROPS_FRAME_LEN) || seg_err_q);
            if (exec && cmd_q == CMD_UI_INFO) begin
                info_o.kind <= cap_q[0];
                info_o.arg <= info_arg;
                info_o.rsp_cnt <= (cap_q[0] == INFO_CONTROL)
                    ? INFO_RSP_TWO : INFO_RSP_ONE;
            end
            if (exec && cmd_q == CMD_GET_CTL) begin
                rd_seg_cnt_o <= seg_cnt;
            end
        end
    end

    // properties are forwarded, never kept; with no client they vanish
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            props_valid_o <= 1'b0;
            props_o <= '0;
        end else begin
            props_valid_o <= exec && cmd_q == CMD_SET_PROPS
                && len_q == PROPS_FRAME_LEN && client_conn_i;
            if (exec && cmd_q == CMD_SET_PROPS) begin
                props_o.id <= id_w;
                // parent dialog visibility is left to the client
                props_o.msg_show <= is_msg
                    && prop0 == PROP_MSG_SHOW;
                props_o.msg_update_only <= is_msg
                    && prop0 == PROP_MSG_UPDATE;
                props_o.icon <= is_msg ? prop2[3:0] : 4'h0;
                // older clients cannot show button sets
                props_o.buttons <= (is_msg && client_v3_i)
                    ? prop2[7:4] : 4'h0;
                props_o.force_visible <= !is_msg
                    && prop0[PROP_VISIBLE_BIT];
                props_o.color_apply <= !is_msg
                    && prop0[PROP_COLOR_BIT];
                props_o.red <= cap_q[6];
                props_o.green <= cap_q[7];
                props_o.blue <= cap_q[8];
            end
        end
    end

    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    info_count_a: assert property (info_valid_o |->
        info_o.rsp_cnt == ((info_o.kind == INFO_CONTROL) ? 2'h2 : 2'h1))
        else $error("info response count wrong");

    props_len_a: assert property (props_valid_o |->
        $past(len_q) == PROPS_FRAME_LEN && $past(cmd_q) == CMD_SET_PROPS)
        else $error("props forwarded from wrong frame length");

    props_client_a: assert property (props_valid_o |->
        $past(client_conn_i))
        else $error("props forwarded without client");

    seg_limit_a: assert property (wr_cnt_q <= SEG_MAX_BYTES)
        else $error("too many write bytes in a segment");

    commit_offset_a: assert property (commit_o |->
        $past(off_w) == 16'h0000 && $past(cmd_q) == CMD_SET_DATA)
        else $error("commit without offset zero write");

    rd_segs_a: assert property (rd_valid_o |->
        rd_seg_cnt_o >= 8'h01
        && rd_seg_cnt_o == 8'(({1'b0, $past(ctl_size)} + 17'h0000f) >> 4)
            + 8'($past(ctl_size) == 16'h0000))
        else $error("read response count wrong");

    id_order_a: assert property (
        in_body && idx_q == POS_ID_LO && cmd_q == CMD_GET_CTL |=>
        ctl_id_o == {cap_q[0], $past(b_data)})
        else $error("control id byte order wrong");

    button_v3_a: assert property (
        props_valid_o && !$past(client_v3_i) |-> props_o.buttons == 4'h0)
        else $error("buttons sent to old client");

    wr_place_a: assert property (wr_byte && !wr_over |=>
        wr_valid_o && wr_o.addr == 16'(off_w + 16'($past(wr_cnt_q))))
        else $error("write byte placed at wrong address");

    exec_once_a: assert property (last_byte |=> exec ##1 !exec)
        else $error("frame end not executed once");

    read_cov_c: cover property (rd_valid_o && rd_seg_cnt_o > 8'h01);
    commit_cov_c: cover property (wr_valid_o ##[1:20] commit_o);
    props_cov_c: cover property (props_valid_o && props_o.color_apply);
    info_cov_c: cover property (info_valid_o
        && info_o.kind == INFO_CONTROL);
endmodule : ui_cmd_interp
`default_nettype wire

//--- hdl/ui_cmd_pkg.sv
// shared constants and carrier types for the ui command interpreter
package ui_cmd_pkg;
    // command bytes
    localparam logic [7:0] CMD_UI_INFO = 8'h07;
    localparam logic [7:0] CMD_GET_CTL = 8'h08;
    localparam logic [7:0] CMD_SET_PROPS = 8'h09;
    localparam logic [7:0] CMD_SET_DATA = 8'h0a;
    // info query selectors
    localparam logic [7:0] INFO_GENERAL = 8'h01;
    localparam logic [7:0] INFO_DIALOG = 8'h02;
    localparam logic [7:0] INFO_CONTROL = 8'h03;
    localparam logic [1:0] INFO_RSP_ONE = 2'h1;
    localparam logic [1:0] INFO_RSP_TWO = 2'h2;
    // frame layout: byte positions inside a frame
    localparam logic [7:0] POS_CMD = 8'h01;
    localparam logic [7:0] POS_CAP_FIRST = 8'h02;
    localparam logic [7:0] POS_CAP_LAST = 8'h0b;
    localparam logic [7:0] POS_ID_LO = 8'h03;
    localparam logic [7:0] POS_DATA = 8'h06;
    localparam int CAP_BYTES = 10;
    localparam logic [7:0] MIN_FRAME_LEN = 8'h02;
    localparam logic [7:0] PROPS_FRAME_LEN = 8'h0c;
    localparam logic [4:0] SEG_MAX_BYTES = 5'h10;
    // property byte flags
    localparam logic [7:0] PROP_MSG_SHOW = 8'h00;
    localparam logic [7:0] PROP_MSG_UPDATE = 8'h01;
    localparam int PROP_VISIBLE_BIT = 4;
    localparam int PROP_COLOR_BIT = 6;
    // control types as presented by the interface store
    localparam logic [3:0] TYPE_BLOB = 4'h0;
    localparam logic [3:0] TYPE_BUTTON = 4'h1;
    localparam logic [3:0] TYPE_DATE_TIME = 4'h2;
    localparam logic [3:0] TYPE_FILES = 4'h3;
    localparam logic [3:0] TYPE_IMAGE = 4'h4;
    localparam logic [3:0] TYPE_LATCH = 4'h5;
    localparam logic [3:0] TYPE_LIST = 4'h6;
    localparam logic [3:0] TYPE_MESSAGE = 4'h7;
    localparam logic [3:0] TYPE_NUMBER = 4'h8;
    localparam logic [3:0] TYPE_PASSWORD = 4'h9;
    localparam logic [3:0] TYPE_SECTION = 4'ha;
    localparam logic [3:0] TYPE_TEXT = 4'hb;
    localparam logic [15:0] SIZE_FLAG = 16'h0001;
    localparam logic [15:0] SIZE_WORD = 16'h0004;
    localparam logic [15:0] SIZE_DATE_TIME = 16'h0008;
    localparam logic [16:0] SEG_ROUND = 17'h0000f;
    // text form characters
    localparam logic [7:0] CHR_CR = 8'h0d;
    localparam logic [7:0] CHR_LF = 8'h0a;

    typedef struct packed {
        logic [7:0] kind;
        logic [15:0] arg;
        logic [1:0] rsp_cnt;
    } info_req_t;

    typedef struct packed {
        logic [15:0] id;
        logic msg_show;
        logic msg_update_only;
        logic [3:0] icon;
        logic [3:0] buttons;
        logic force_visible;
        logic color_apply;
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } props_t;

    typedef struct packed {
        logic [15:0] id;
        logic [15:0] addr;
        logic [7:0] data;
    } wr_t;
endpackage : ui_cmd_pkg

//--- hdl/hex_pair_decoder.sv
// turns the text form of a frame (hex pairs, cr/lf) into bytes
`timescale 1ns/100ps
`default_nettype none
module hex_pair_decoder
    import ui_cmd_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic text_mode_i,
    input wire logic in_valid_i,
    input wire logic [7:0] in_data_i,
    output logic out_valid_o,
    output logic [7:0] out_data_o
);
    logic have_hi_q;
    logic have_hi_d;
    logic [3:0] hi_q;
    logic [3:0] nib;
    logic is_hex;
    logic is_eol;
    logic emit;

    // character classification
    assign is_eol = (in_data_i == CHR_CR) || (in_data_i == CHR_LF);
    assign is_hex = (in_data_i inside {[8'h30:8'h39]})
        || (in_data_i inside {[8'h41:8'h46]})
        || (in_data_i inside {[8'h61:8'h66]});
    assign nib = (in_data_i <= 8'h39) ? in_data_i[3:0]
        : 4'(in_data_i[3:0] + 4'h9);
    assign emit = in_valid_i && (text_mode_i ? (is_hex && have_hi_q) : 1'b1);
    // a lone nibble before the line end is dropped, not half-used
    assign have_hi_d = (in_valid_i && text_mode_i)
        ? (is_eol ? 1'b0 : (is_hex ? !have_hi_q : have_hi_q))
        : (text_mode_i ? have_hi_q : 1'b0);

    // byte assembly; binary bytes pass through with one cycle of delay
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            have_hi_q <= 1'b0;
            hi_q <= 4'h0;
            out_valid_o <= 1'b0;
            out_data_o <= 8'h00;
        end else begin
            have_hi_q <= have_hi_d;
            if (in_valid_i && is_hex) begin
                hi_q <= nib;
            end
            out_valid_o <= emit;
            if (emit) begin
                out_data_o <= text_mode_i ? {hi_q, nib} : in_data_i;
            end
        end
    end
endmodule : hex_pair_decoder
`default_nettype wire

//--- tb/host_store_model.sv
// host link and control store model facing the command interpreter
`timescale 1ns/100ps
`default_nettype none
module host_store_model
    import ui_cmd_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic [15:0] ctl_id_i,
    output var logic rx_valid_o,
    output var logic [7:0] rx_data_o,
    output var logic text_mode_o,
    output logic [3:0] ctl_type_o,
    output logic [15:0] ctl_cfg_size_o
);
    // store lookup: low nibble is the type, high byte the configured size
    assign ctl_type_o = ctl_id_i[3:0];
    assign ctl_cfg_size_o = {8'h00, ctl_id_i[15:8]};

    initial begin
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
        text_mode_o = 1'b0;
    end

    // one byte or character per cycle, just after the edge
    task automatic put(input logic [7:0] b);
        @(posedge clk_sys_i);
        #1;
        rx_valid_o = 1'b1;
        rx_data_o = b;
    endtask : put

    function automatic logic [7:0] hexc(input logic [3:0] n);
        return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
    endfunction : hexc

    // frames start with their total length; text form as hex pairs
    task automatic send(input logic txt, input logic [7:0] q[$]);
        @(posedge clk_sys_i);
        #1;
        text_mode_o = txt;
        foreach (q[i]) begin
            if (txt) begin
                put(hexc(q[i][7:4]));
                put(hexc(q[i][3:0]));
            end else begin
                put(q[i]);
            end
        end
        if (txt) begin
            put(CHR_CR);
            put(CHR_LF);
        end
        @(posedge clk_sys_i);
        #1;
        rx_valid_o = 1'b0;
        // idle data is scrambled so a stale byte is never reused
        rx_data_o = ~rx_data_o;
    endtask : send
endmodule : host_store_model
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the ui command interpreter
`timescale 1ns/100ps
`default_nettype none
module tb
    import ui_cmd_pkg::*;
;
    logic clk_sys_i, sys_rst_i, conn, v3;
    wire logic rx_valid, text_mode;
    wire logic [7:0] rx_data;
    wire logic [3:0] ctl_type;
    wire logic [15:0] cfg_size, ctl_id;
    logic info_valid, rd_valid, props_valid, wr_valid, commit, frame_err;
    logic [7:0] seg_cnt;
    info_req_t info;
    props_t props;
    wr_t wr;
    int bad_count = 0, samples_checked = 0;
    int n_info, n_rd, n_props, n_commit, n_err;
    wr_t wr_q[$];

    ui_cmd_interp i_ui_cmd_interp (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
        .text_mode_i(text_mode), .client_conn_i(conn), .client_v3_i(v3),
        .ctl_type_i(ctl_type), .ctl_cfg_size_i(cfg_size),
        .ctl_id_o(ctl_id), .info_valid_o(info_valid), .info_o(info),
        .rd_valid_o(rd_valid), .rd_seg_cnt_o(seg_cnt),
        .props_valid_o(props_valid), .props_o(props),
        .wr_valid_o(wr_valid), .wr_o(wr), .commit_o(commit),
        .frame_err_o(frame_err));
    host_store_model i_host_store_model (.clk_sys_i(clk_sys_i),
        .ctl_id_i(ctl_id), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
        .text_mode_o(text_mode), .ctl_type_o(ctl_type),
        .ctl_cfg_size_o(cfg_size));

    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    // pulses are counted here, so a doubled pulse shows up as a count
    always @(posedge clk_sys_i) begin
        if (info_valid === 1'b1) n_info++;
        if (rd_valid === 1'b1) n_rd++;
        if (props_valid === 1'b1) n_props++;
        if (commit === 1'b1) n_commit++;
        if (frame_err === 1'b1) n_err++;
        if (wr_valid === 1'b1) wr_q.push_back(wr);
    end

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // clear counters, send one stream, let the results land
    task automatic go(input logic txt, input logic [7:0] q[$]);
        {n_info, n_rd, n_props, n_commit, n_err} = '0;
        wr_q.delete();
        i_host_store_model.send(txt, q);
        repeat (4) @(posedge clk_sys_i);
        #1;
    endtask : go

    task automatic t_read();
        logic [15:0] ids[8] = '{16'h1238, 16'h0005, 16'h0109, 16'h1000,
            16'h1100, 16'h2100, 16'h0002, 16'h0001};
        logic [7:0] exp[8] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h02, 8'h03,
            8'h01, 8'h01};
        foreach (ids[i]) begin
            go(1'b0, {8'h04, CMD_GET_CTL, ids[i][15:8], ids[i][7:0]});
            chk(n_rd, 1);
            chk(ctl_id, ids[i]);
            chk(seg_cnt, exp[i]);
        end
    endtask : t_read

    task automatic t_info();
        go(1'b0, {8'h03, CMD_UI_INFO, INFO_GENERAL});
        chk({n_info, info.kind, info.rsp_cnt}, {32'd1, 8'h01, 2'h1});
        go(1'b0, {8'h04, CMD_UI_INFO, INFO_DIALOG, 8'h05});
        chk({n_info, info.arg, info.rsp_cnt}, {32'd1, 16'h5, 2'h1});
        go(1'b0, {8'h05, CMD_UI_INFO, INFO_CONTROL, 8'h12, 8'h34});
        chk({n_info, info.arg, info.rsp_cnt}, {32'd1, 16'h1234, 2'h2});
        chk(ctl_id, 16'h1234);
        go(1'b0, {8'h03, CMD_UI_INFO, 8'h09});
        chk({n_info, info.kind}, {32'd1, 8'h09});
    endtask : t_info

    task automatic t_text();
        go(1'b1, {8'h04, CMD_GET_CTL, 8'h12, 8'h38});
        chk({n_rd, ctl_id}, {32'd1, 16'h1238});
    endtask : t_text

    // properties frame; an 0x0b length drops the last byte
    task automatic pr(input logic [7:0] len, input logic [15:0] id,
            input logic [7:0] b0, input logic [7:0] b2);
        logic [7:0] q[$];
        q = {len, CMD_SET_PROPS, id[15:8], id[7:0], b0, 8'h00, b2, 8'h00,
            8'hff, 8'h80, 8'h01, 8'h00};
        if (len == 8'h0b) void'(q.pop_back());
        go(1'b0, q);
    endtask : pr

    task automatic t_props();
        conn = 1'b1;
        v3 = 1'b1;
        pr(8'h0c, 16'h0b07, 8'h00, 8'h45);
        chk({n_props, n_err, props.id}, {32'd1, 32'd0, 16'h0b07});
        chk({props.msg_show, props.msg_update_only}, 2'b10);
        chk({props.icon, props.buttons}, 8'h54);
        v3 = 1'b0;
        pr(8'h0c, 16'h0b07, 8'h01, 8'h63);
        chk({props.msg_show, props.msg_update_only}, 2'b01);
        chk({props.icon, props.buttons}, 8'h30);
        pr(8'h0c, 16'h0003, 8'h50, 8'h00);
        chk({props.force_visible, props.color_apply}, 2'b11);
        chk({props.red, props.green, props.blue}, 24'hff8001);
        pr(8'h0c, 16'h0003, 8'h40, 8'h00);
        chk({props.force_visible, props.color_apply}, 2'b01);
        pr(8'h0b, 16'h0003, 8'h50, 8'h00);
        chk({n_props, n_err}, {32'd0, 32'd1});
        conn = 1'b0;
        pr(8'h0c, 16'h0003, 8'h50, 8'h00);
        chk({n_props, n_err}, {32'd0, 32'd0});
    endtask : t_props

    task automatic t_write();
        logic [7:0] q[$];
        go(1'b0, {8'h08, CMD_SET_DATA, 8'h30, 8'h0b, 8'h10, 8'h02, 8'haa,
            8'hbb});
        chk({wr_q.size(), n_commit}, {32'd2, 32'd0});
        chk(wr_q[0], {16'h300b, 16'h0210, 8'haa});
        chk(wr_q[1], {16'h300b, 16'h0211, 8'hbb});
        // final segment followed at once by a read frame
        go(1'b0, {8'h07, CMD_SET_DATA, 8'h30, 8'h0b, 8'h00, 8'h00, 8'hcc,
            8'h04, CMD_GET_CTL, 8'h30, 8'h0b});
        chk({wr_q.size(), n_commit, n_rd}, {32'd1, 32'd1, 32'd1});
        chk(wr_q[0], {16'h300b, 16'h0000, 8'hcc});
        chk(seg_cnt, 8'h03);
        q = {8'h17, CMD_SET_DATA, 8'h30, 8'h0b, 8'h00, 8'h00};
        for (int i = 0; i < 17; i++) q.push_back(8'(i));
        go(1'b0, q);
        chk({wr_q.size(), n_err, n_commit}, {32'd16, 32'd1, 32'd0});
        chk(wr_q[15], {16'h300b, 16'h000f, 8'h0f});
    endtask : t_write

    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    initial begin
        sys_rst_i = 1'b1;
        conn = 1'b0;
        v3 = 1'b0;
        repeat (6) @(posedge clk_sys_i);
        #1;
        sys_rst_i = 1'b0;
        chk({info_valid, rd_valid, props_valid, wr_valid, commit}, 5'h00);
        t_read();
        t_info();
        t_text();
        t_props();
        t_write();
        summarize();
    end

    // the whole run is a few hundred cycles; this cuts off a hang
    initial begin
        #100000;
        bad_count++;
        summarize();
    end
endmodule : tb
`default_nettype wire
